// *** src/fslh_defs.svh ***
`ifndef FSLH_DEFS_SVH
`define FSLH_DEFS_SVH

// Register map
`define FSLH_FAILSAFE_CONTROL_ADDR   7'h02
`define FSLH_FAILSAFE_CONTROL_RESET  8'h00

// Field positions of failsafe_control
`define FSLH_SHUTDOWN_SEL_HI         7
`define FSLH_SHUTDOWN_SEL_LO         6
`define FSLH_DRIVE_TYPE_BIT          5
`define FSLH_OUT_SEL_HI              4
`define FSLH_OUT_SEL_LO              3
`define FSLH_LIMP_BIT                2
`define FSLH_TALLY_HI                1
`define FSLH_TALLY_LO                0
`define FSLH_TALLY_MAX               2'h3

// Serial frame: 7 address bits, read-only flag, 8 data bits
`define FSLH_FRAME_BITS              5'h10
`define FSLH_HEADER_BITS             5'h08

// Clock and timing
`define FSLH_SYS_CLK_HZ              50000000
`define FSLH_PWM_FREQ_HZ             100
`define FSLH_PWM_DUTY_PCT            10
`define FSLH_HAZARD_FREQ_CENTI_HZ    125
`define FSLH_HAZARD_DUTY_PCT         50
`define FSLH_RESET_PULSE_US          1000
`define FSLH_PWM_PERIOD_CYC    (`FSLH_SYS_CLK_HZ / `FSLH_PWM_FREQ_HZ)
`define FSLH_PWM_HIGH_CYC      (`FSLH_PWM_PERIOD_CYC * `FSLH_PWM_DUTY_PCT / 100)
`define FSLH_HAZARD_PERIOD_CYC (`FSLH_SYS_CLK_HZ / `FSLH_HAZARD_FREQ_CENTI_HZ * 100)
`define FSLH_HAZARD_HIGH_CYC   (`FSLH_HAZARD_PERIOD_CYC * `FSLH_HAZARD_DUTY_PCT / 100)
`define FSLH_RESET_PULSE_CYC   (`FSLH_SYS_CLK_HZ / 1000000 * `FSLH_RESET_PULSE_US)

`endif

// *** src/fslh_pkg.sv ***
package fslh_pkg;

   // Chip operating modes seen by the fail-safe logic
   typedef enum logic [2:0] {
      FSLH_MODE_OFF,
      FSLH_MODE_STANDBY,
      FSLH_MODE_NORMAL,
      FSLH_MODE_RESET,
      FSLH_MODE_OVERLOAD,
      FSLH_MODE_PROTECT
   } fslh_mode_t;

endpackage

// *** src/fslh_failsafe_limp_home_control.sv ***
// Notes on behaviour
// - Shutdown select 7:6 forces aux output low on never, undervoltage, overvoltage, both.
// - Bit 5 picks push-pull at 0, open-drain low-side only at 1.
// - Output select 00 keeps aux output low; 11 lets timer 2 drive it.
// - Select 01 releases aux output high in Normal, Reset and Standby.
// - Select 10 releases aux output high only in Normal, else low.
// - Limp bit 2 floats the limp pin at 0, pulls low at 1.
// - Reset tally counts system resets above switcher undervoltage, saturating at 3.
// - Limp pin is active-low open drain: pulls low or floats.
// - Limp bit set on Overload entry and on fail-safe protect entry.
// - Limp bit cleared automatically on entry to Off mode.
// - Host clears limp bit; pin released in the same cycle.
// - Configured I/O 2 drives high-side as static limp supply.
// - Configured I/O 3 drives 100 Hz, 10 % duty while limp active.
// - Configured I/O 4 drives 1.25 Hz, 50 % clock while limp active.
// - I/O 2, 3, 4 each chosen limp or standard by start-up configuration.
// - Overtemperature activation enters Overload: reset low, limp low, I/O limp on.
// - Overload disables converter, transceivers, regulators; I/O pins fail-safe.
// - Below release threshold, Overload exits through Reset into Standby.
// - Overtemperature warning raises its interrupt when enabled.
// - Battery-fault shutdown acts in Normal only and overrides output select.
// - Tally already 3 on Reset entry goes to fail-safe protect instead.
`timescale 1ns/1ps
`include "fslh_defs.svh"

module fslh_failsafe_limp_home_control
   import fslh_pkg::*;
#(
   parameter int unsigned PWM_PERIOD_CYC    = `FSLH_PWM_PERIOD_CYC,
   parameter int unsigned PWM_HIGH_CYC      = `FSLH_PWM_HIGH_CYC,
   parameter int unsigned HAZARD_PERIOD_CYC = `FSLH_HAZARD_PERIOD_CYC,
   parameter int unsigned HAZARD_HIGH_CYC   = `FSLH_HAZARD_HIGH_CYC,
   parameter int unsigned RESET_PULSE_CYC   = `FSLH_RESET_PULSE_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       clk_en,
   // Serial register port
   input  wire logic       spi_cs_n,
   input  wire logic       spi_sck,
   input  wire logic       spi_mosi,
   output logic            spi_miso,
   // Comparator and system inputs
   input  wire logic       otp_activate,
   input  wire logic       otp_release,
   input  wire logic       otp_warn,
   input  wire logic       otp_warn_irq_en,
   input  wire logic       bat_undervolt,
   input  wire logic       bat_overvolt,
   input  wire logic       switcher_battery_supply_uv,
   input  wire logic       power_off_det,
   input  wire logic       power_on_det,
   input  wire logic       sys_reset_req,
   input  wire logic       normal_mode_req,
   input  wire logic       timer2_level,
   input  wire logic [2:0] nvm_limp_cfg,
   // Pins
   output logic            aux_out,
   output logic            aux_out_oe,
   output logic            limp_out,
   output logic            limp_out_oe,
   output logic            sys_reset_out_n,
   output logic            limp_static_drive,
   output logic            limp_pwm_drive,
   output logic            hazard_clock_drive,
   output logic            overtemp_warn_irq,
   // Supply enables
   output logic            switcher_en,
   output logic            can_en,
   output logic            lin_en,
   output logic            regulators_en,
   output logic            hvio_failsafe,
   output fslh_mode_t      mode
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   fslh_mode_t  mode_reg,      mode_next;
   logic [7:0]  ctrl_reg,      ctrl_next;
   logic [31:0] rst_cnt_reg,   rst_cnt_next;
   logic [31:0] pwm_cnt_reg,   pwm_cnt_next;
   logic [31:0] haz_cnt_reg,   haz_cnt_next;
   logic [4:0]  bit_cnt_reg,   bit_cnt_next;
   logic [15:0] shift_in_reg,  shift_in_next;
   logic [7:0]  shift_out_reg, shift_out_next;
   logic        sck_prev_reg;
   logic        cs_prev_reg;
   logic        warn_prev_reg;
   logic        irq_reg;
   logic        aux_out_reg,   aux_oe_reg;
   logic [2:0]  hvio_reg,      hvio_next;
   logic        sys_reset_out_n_reg;
   wire         sck_rise    = ~spi_cs_n & spi_sck & ~sck_prev_reg;
   wire         sck_fall    = ~spi_cs_n & ~spi_sck & sck_prev_reg;
   wire         frame_end   = spi_cs_n & ~cs_prev_reg;
   wire         addr_hit    = (shift_in_reg[15:9] == `FSLH_FAILSAFE_CONTROL_ADDR);
   wire         header_done = sck_rise & (bit_cnt_reg == `FSLH_HEADER_BITS - 5'h01);
   wire         spi_write   = frame_end & (bit_cnt_reg == `FSLH_FRAME_BITS)
                              & addr_hit & ~shift_in_reg[8];

   ////////////////////////////////////////////////////////////////////////////
   // Serial register port

   // Shift in on rising clock, shift out on falling, count bits per frame
   always_comb begin
      bit_cnt_next   = bit_cnt_reg;
      shift_in_next  = shift_in_reg;
      shift_out_next = shift_out_reg;
      if (spi_cs_n) begin
         bit_cnt_next = 5'h00;
      end else if (sck_rise) begin
         shift_in_next = {shift_in_reg[14:0], spi_mosi};
         if (bit_cnt_reg != 5'h1F) begin
            bit_cnt_next = bit_cnt_reg + 5'h01;
         end
      end
      // Data phase answers with the register, unmapped addresses read zero
      if (header_done) begin
         shift_out_next = (shift_in_reg[6:0] == `FSLH_FAILSAFE_CONTROL_ADDR) ?
                          ctrl_reg : 8'h00;
      end else if (sck_fall && bit_cnt_reg >= `FSLH_HEADER_BITS) begin
         shift_out_next = {shift_out_reg[6:0], 1'b0};
      end
   end

   assign spi_miso = shift_out_reg[7];

   ////////////////////////////////////////////////////////////////////////////
   // Mode sequencing

   wire tally_full = (ctrl_reg[`FSLH_TALLY_HI:`FSLH_TALLY_LO] == `FSLH_TALLY_MAX);
   wire rst_done   = (rst_cnt_reg >= RESET_PULSE_CYC - 1);

   // Power loss wins, then overtemperature, then ordinary reset sources
   always_comb begin
      mode_next    = mode_reg;
      rst_cnt_next = 32'h0000_0000;
      case (mode_reg)
         FSLH_MODE_OFF: begin
            if (power_on_det) begin
               mode_next = FSLH_MODE_RESET;
            end
         end
         FSLH_MODE_STANDBY: begin
            if (sys_reset_req) begin
               mode_next = FSLH_MODE_RESET;
            end else if (normal_mode_req) begin
               mode_next = FSLH_MODE_NORMAL;
            end
         end
         FSLH_MODE_NORMAL: begin
            if (sys_reset_req) begin
               mode_next = FSLH_MODE_RESET;
            end else if (!normal_mode_req) begin
               mode_next = FSLH_MODE_STANDBY;
            end
         end
         FSLH_MODE_RESET: begin
            rst_cnt_next = rst_cnt_reg + 32'h0000_0001;
            if (rst_done) begin
               mode_next = FSLH_MODE_STANDBY;
            end
         end
         FSLH_MODE_OVERLOAD: begin
            if (otp_release) begin
               mode_next = FSLH_MODE_RESET;
            end
         end
         FSLH_MODE_PROTECT: begin
            // Left only by power loss or overtemperature
         end
         default: begin
            mode_next = FSLH_MODE_OFF;
         end
      endcase
      // Full tally diverts a fresh reset entry into protect mode
      if (mode_next == FSLH_MODE_RESET && mode_reg != FSLH_MODE_RESET && tally_full) begin
         mode_next = FSLH_MODE_PROTECT;
      end
      if (otp_activate && mode_reg != FSLH_MODE_OFF) begin
         mode_next = FSLH_MODE_OVERLOAD;
      end
      if (power_off_det) begin
         mode_next = FSLH_MODE_OFF;
      end
   end

   wire enter_reset    = (mode_next == FSLH_MODE_RESET) && (mode_reg != FSLH_MODE_RESET);
   wire enter_overload = (mode_next == FSLH_MODE_OVERLOAD) && (mode_reg != FSLH_MODE_OVERLOAD);
   wire enter_protect  = (mode_next == FSLH_MODE_PROTECT) && (mode_reg != FSLH_MODE_PROTECT);
   wire enter_off      = (mode_next == FSLH_MODE_OFF) && (mode_reg != FSLH_MODE_OFF);

   ////////////////////////////////////////////////////////////////////////////
   // Control register

   // Hardware updates land after the host write, so a set is never lost
   always_comb begin
      ctrl_next = ctrl_reg;
      if (spi_write) begin
         ctrl_next = shift_in_reg[7:0];
      end
      if (enter_reset && !switcher_battery_supply_uv && !tally_full) begin
         ctrl_next[`FSLH_TALLY_HI:`FSLH_TALLY_LO] =
            ctrl_reg[`FSLH_TALLY_HI:`FSLH_TALLY_LO] + 2'h1;
      end
      if (enter_overload || enter_protect) begin
         ctrl_next[`FSLH_LIMP_BIT] = 1'b1;
      end
      if (enter_off) begin
         ctrl_next[`FSLH_LIMP_BIT] = 1'b0;
      end
   end

   wire [1:0] shutdown_sel = ctrl_reg[`FSLH_SHUTDOWN_SEL_HI:`FSLH_SHUTDOWN_SEL_LO];
   wire [1:0] out_sel      = ctrl_reg[`FSLH_OUT_SEL_HI:`FSLH_OUT_SEL_LO];
   wire       open_drain   = ctrl_reg[`FSLH_DRIVE_TYPE_BIT];
   wire       limp_active  = ctrl_reg[`FSLH_LIMP_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Auxiliary output

   // Battery fault only counts in Normal and then overrides the select
   wire bat_fault = (mode_reg == FSLH_MODE_NORMAL) &&
                    ((shutdown_sel[0] && bat_undervolt) ||
                     (shutdown_sel[1] && bat_overvolt));
   wire sel_high  = (out_sel == 2'h1) ? (mode_reg == FSLH_MODE_NORMAL ||
                                         mode_reg == FSLH_MODE_RESET ||
                                         mode_reg == FSLH_MODE_STANDBY) :
                    (out_sel == 2'h2) ? (mode_reg == FSLH_MODE_NORMAL) :
                    (out_sel == 2'h3) ? timer2_level :
                    1'b0;
   wire aux_high  = sel_high && !bat_fault;
   // Open drain never drives high, it only lets go of the pin
   wire aux_oe_d  = !aux_high || !open_drain;

   ////////////////////////////////////////////////////////////////////////////
   // Limp-home pins

   // Straight from the bit so a clear releases the pin at once
   assign limp_out    = 1'b0;
   assign limp_out_oe = limp_active;

   // Waveform counters free-run only while limp is active
   assign pwm_cnt_next = (!limp_active || pwm_cnt_reg >= PWM_PERIOD_CYC - 1) ?
                         32'h0000_0000 : pwm_cnt_reg + 32'h0000_0001;
   assign haz_cnt_next = (!limp_active || haz_cnt_reg >= HAZARD_PERIOD_CYC - 1) ?
                         32'h0000_0000 : haz_cnt_reg + 32'h0000_0001;
   wire [2:0] wave = {haz_cnt_reg < HAZARD_HIGH_CYC,
                      pwm_cnt_reg < PWM_HIGH_CYC,
                      1'b1};

   // One gate per pin: start-up choice, limp state and its waveform
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_hvio
         assign hvio_next[gi] = nvm_limp_cfg[gi] && limp_active && wave[gi];
      end
   endgenerate
   assign limp_static_drive  = hvio_reg[0];
   assign limp_pwm_drive     = hvio_reg[1];
   assign hazard_clock_drive = hvio_reg[2];

   ////////////////////////////////////////////////////////////////////////////
   // Supplies and reset pin

   wire shut_down = (mode_reg == FSLH_MODE_OVERLOAD) || (mode_reg == FSLH_MODE_OFF);
   assign switcher_en   = !shut_down;
   assign can_en        = !shut_down;
   assign lin_en        = !shut_down;
   assign regulators_en = !shut_down;
   assign hvio_failsafe = (mode_reg == FSLH_MODE_OVERLOAD);
   assign mode          = mode_reg;
   assign aux_out           = aux_out_reg;
   assign aux_out_oe        = aux_oe_reg;
   assign sys_reset_out_n   = sys_reset_out_n_reg;
   assign overtemp_warn_irq = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // State registers

   // Mode, control register and counters
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mode_reg    <= FSLH_MODE_OFF;
         ctrl_reg    <= `FSLH_FAILSAFE_CONTROL_RESET;
         rst_cnt_reg <= 32'h0000_0000;
         pwm_cnt_reg <= 32'h0000_0000;
         haz_cnt_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         mode_reg    <= mode_next;
         ctrl_reg    <= ctrl_next;
         rst_cnt_reg <= rst_cnt_next;
         pwm_cnt_reg <= pwm_cnt_next;
         haz_cnt_reg <= haz_cnt_next;
      end
   end

   // Serial port shift state
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bit_cnt_reg   <= 5'h00;
         shift_in_reg  <= 16'h0000;
         shift_out_reg <= 8'h00;
         sck_prev_reg  <= 1'b0;
         cs_prev_reg   <= 1'b1;
      end else if (clk_en) begin
         bit_cnt_reg   <= bit_cnt_next;
         shift_in_reg  <= shift_in_next;
         shift_out_reg <= shift_out_next;
         sck_prev_reg  <= spi_sck;
         cs_prev_reg   <= spi_cs_n;
      end
   end

   // Registered pin drivers; reset pin low in Reset and Overload
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         aux_out_reg   <= 1'b0;
         aux_oe_reg    <= 1'b1;
         hvio_reg      <= 3'h0;
         sys_reset_out_n_reg      <= 1'b0;
         warn_prev_reg <= 1'b0;
         irq_reg       <= 1'b0;
      end else if (clk_en) begin
         aux_out_reg   <= aux_high && !open_drain;
         aux_oe_reg    <= aux_oe_d;
         hvio_reg      <= hvio_next;
         sys_reset_out_n_reg      <= (mode_next != FSLH_MODE_RESET) &&
                          (mode_next != FSLH_MODE_OVERLOAD);
         warn_prev_reg <= otp_warn;
         irq_reg       <= otp_warn && !warn_prev_reg && otp_warn_irq_en;
      end
   end

endmodule

// *** tb/fslh_failsafe_limp_home_control_properties.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
module fslh_failsafe_limp_home_control_properties
   import fslh_pkg::*;
#(
   parameter int unsigned PWM_HIGH_CYC = 2
) (
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire logic       clk_en,
   input wire logic       otp_activate,
   input wire logic       otp_release,
   input wire logic       otp_warn,
   input wire logic       otp_warn_irq_en,
   input wire logic       power_off_det,
   input wire logic [2:0] nvm_limp_cfg,
   input wire logic       limp_out,
   input wire logic       limp_out_oe,
   input wire logic       sys_reset_out_n,
   input wire logic       limp_static_drive,
   input wire logic       limp_pwm_drive,
   input wire logic       overtemp_warn_irq,
   input wire logic       switcher_en,
   input wire logic       can_en,
   input wire logic       regulators_en,
   input wire logic       hvio_failsafe,
   input wire fslh_mode_t mode
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // High run length of the PWM pin, frozen with the clock enable
   int unsigned pwm_run;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         pwm_run <= 0;
      else if (clk_en)
         pwm_run <= limp_pwm_drive ? pwm_run + 1 : 0;
   end

   ////////////////////////////////////////
   // Overtemperature and mode handling
   property p_ovl_entry;
      otp_activate && clk_en && !power_off_det && mode != FSLH_MODE_OFF
         |=> mode == FSLH_MODE_OVERLOAD;
   endproperty
   a_ovl_entry: assert property (p_ovl_entry) else $error("overload not entered");
   property p_ovl_reset;
      mode == FSLH_MODE_OVERLOAD && clk_en && !power_off_det |=> !sys_reset_out_n;
   endproperty
   a_ovl_reset: assert property (p_ovl_reset) else $error("reset pin high in overload");
   property p_ovl_limp;
      mode == FSLH_MODE_OVERLOAD && $past(mode) != FSLH_MODE_OVERLOAD |-> ##[0:1] limp_out_oe;
   endproperty
   a_ovl_limp: assert property (p_ovl_limp) else $error("limp not set on overload");
   property p_ovl_supplies;
      mode == FSLH_MODE_OVERLOAD |-> !switcher_en && !can_en && !regulators_en && hvio_failsafe;
   endproperty
   a_ovl_supplies: assert property (p_ovl_supplies) else $error("supply on in overload");
   property p_ovl_release;
      mode == FSLH_MODE_OVERLOAD && otp_release && !otp_activate && !power_off_det && clk_en
         |=> mode == FSLH_MODE_RESET;
   endproperty
   a_ovl_release: assert property (p_ovl_release) else $error("overload exit wrong");
   property p_off_clear;
      mode == FSLH_MODE_OFF && $past(mode) != FSLH_MODE_OFF |-> ##[0:1] !limp_out_oe;
   endproperty
   a_off_clear: assert property (p_off_clear) else $error("limp kept in off");

   ////////////////////////////////////////
   // Pins and interrupt
   property p_limp_od;
      limp_out_oe |-> !limp_out;
   endproperty
   a_limp_od: assert property (p_limp_od) else $error("limp pin driven high");
   property p_warn_irq;
      $rose(otp_warn) && otp_warn_irq_en && clk_en |-> ##[1:2] overtemp_warn_irq;
   endproperty
   a_warn_irq: assert property (p_warn_irq) else $error("warning irq missing");
   property p_warn_pulse;
      overtemp_warn_irq && clk_en |=> !overtemp_warn_irq;
   endproperty
   a_warn_pulse: assert property (p_warn_pulse) else $error("warning irq too long");
   property p_static;
      (nvm_limp_cfg[0] && limp_out_oe && clk_en)[*2] |-> limp_static_drive;
   endproperty
   a_static: assert property (p_static) else $error("static limp off");
   property p_std_io;
      (!nvm_limp_cfg[0])[*2] |-> !limp_static_drive;
   endproperty
   a_std_io: assert property (p_std_io) else $error("static limp on unselected");
   property p_pwm_high;
      $fell(limp_pwm_drive) && limp_out_oe && $past(limp_out_oe) |-> pwm_run == PWM_HIGH_CYC;
   endproperty
   a_pwm_high: assert property (p_pwm_high) else $error("pwm high time wrong");

   // Main scenarios reached
   c_protect: cover property (mode == FSLH_MODE_PROTECT);
   c_overload: cover property (mode == FSLH_MODE_OVERLOAD);
   c_irq: cover property (overtemp_warn_irq);
endmodule

bind fslh_failsafe_limp_home_control fslh_failsafe_limp_home_control_properties
   #(.PWM_HIGH_CYC(PWM_HIGH_CYC)) u_props (
   .sys_clk, .nrst, .clk_en, .otp_activate, .otp_release, .otp_warn, .otp_warn_irq_en,
   .power_off_det, .nvm_limp_cfg, .limp_out, .limp_out_oe, .sys_reset_out_n,
   .limp_static_drive, .limp_pwm_drive, .overtemp_warn_irq, .switcher_en, .can_en,
   .regulators_en, .hvio_failsafe, .mode);

// *** tb/fslh_host_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
module fslh_host_model (
   input  wire logic sys_clk,
   input  wire logic spi_miso,
   output logic      spi_cs_n,
   output logic      spi_sck,
   output logic      spi_mosi
);
   // Idle bus: deselected, clock parked low
   initial begin
      {spi_cs_n, spi_sck, spi_mosi} = 3'b100;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask

   // One frame, msb first; gap = sck phase in clocks, short frames allowed
   task automatic xfer(input logic [6:0] a, input logic ro, input logic [7:0] d,
                       input int nbits, input int gap, output logic [7:0] q);
      logic [15:0] f;
      f = {a, ro, d};
      q = 8'h00;
      spi_cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         spi_mosi = f[15 - i];
         wait_clk(gap);
         spi_sck = 1'b1;
         wait_clk(gap);
         if (i >= 7 && i < 15)
            q = {q[6:0], spi_miso};
         spi_sck = 1'b0;
      end
      wait_clk(gap);
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi; // Released line shows no stale value
      wait_clk(3);
   endtask
endmodule

// *** tb/tb_failsafe_limp_home_control.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
module tb_failsafe_limp_home_control;
   import fslh_pkg::*;
   logic sys_clk, nrst, clk_en, spi_cs_n, spi_sck, spi_mosi, spi_miso;
   logic otp_activate, otp_release, otp_warn, otp_warn_irq_en, bat_undervolt, bat_overvolt;
   logic switcher_battery_supply_uv, power_off_det, power_on_det, sys_reset_req;
   logic normal_mode_req, timer2_level, aux_out, aux_out_oe, limp_out, limp_out_oe;
   logic sys_reset_out_n, limp_static_drive, limp_pwm_drive, hazard_clock_drive;
   logic overtemp_warn_irq, switcher_en, can_en, lin_en, regulators_en, hvio_failsafe;
   logic [2:0]  nvm_limp_cfg;
   logic [7:0]  q, d;
   logic [31:0] seed;
   fslh_mode_t  mode, em;
   int          mismatches, num_checks, n, h;

   fslh_failsafe_limp_home_control #(.PWM_PERIOD_CYC(20), .PWM_HIGH_CYC(2),
      .HAZARD_PERIOD_CYC(40), .HAZARD_HIGH_CYC(20), .RESET_PULSE_CYC(5)) dut (
      .sys_clk, .nrst, .clk_en, .spi_cs_n, .spi_sck, .spi_mosi, .spi_miso, .otp_activate,
      .otp_release, .otp_warn, .otp_warn_irq_en, .bat_undervolt, .bat_overvolt,
      .switcher_battery_supply_uv, .power_off_det, .power_on_det, .sys_reset_req,
      .normal_mode_req, .timer2_level, .nvm_limp_cfg, .aux_out, .aux_out_oe, .limp_out,
      .limp_out_oe, .sys_reset_out_n, .limp_static_drive, .limp_pwm_drive,
      .hazard_clock_drive, .overtemp_warn_irq, .switcher_en, .can_en, .lin_en,
      .regulators_en, .hvio_failsafe, .mode);

   fslh_host_model host (.sys_clk, .spi_miso, .spi_cs_n, .spi_sck, .spi_mosi);

   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #2;
   endtask

   task automatic wr(input logic [7:0] v);
      host.xfer(7'h02, 1'b0, v, 16, 3, q);
      cyc(2);
   endtask

   task automatic rd_chk(input logic [7:0] v);
      host.xfer(7'h02, 1'b1, 8'h00, 16, 3, q);
      check(q, v);
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected aux pin as {driven, level}; open drain never drives high
   function automatic logic [1:0] aux_exp(input logic [7:0] c, input fslh_mode_t m);
      logic hi;
      if (m == FSLH_MODE_NORMAL && ((c[6] && bat_undervolt) || (c[7] && bat_overvolt)))
         return 2'b10;
      case (c[4:3])
         2'b00: hi = 1'b0;
         2'b01: hi = m inside {FSLH_MODE_NORMAL, FSLH_MODE_RESET, FSLH_MODE_STANDBY};
         2'b10: hi = m == FSLH_MODE_NORMAL;
         default: hi = timer2_level;
      endcase
      return hi ? (c[5] ? 2'b00 : 2'b11) : 2'b10;
   endfunction

   task automatic aux_chk(input logic [7:0] c, input fslh_mode_t m);
      logic [1:0] e;
      e = aux_exp(c, m);
      check(8'(aux_out_oe), 8'(e[1]));
      if (e[1])
         check(8'(aux_out), 8'(e[0]));
   endtask

   ////////////////////////////////////////
   // Main sequence
   initial begin
      {otp_activate, otp_release, otp_warn, otp_warn_irq_en, bat_undervolt} = 5'h00;
      {bat_overvolt, switcher_battery_supply_uv, power_off_det, power_on_det} = 4'h0;
      {sys_reset_req, normal_mode_req, timer2_level} = 3'h0;
      {mismatches, num_checks} = 0;
      nvm_limp_cfg = 3'b110;
      clk_en = 1'b1;
      nrst = 1'b0;
      seed = 32'h8877;
      repeat (20) @(posedge sys_clk);
      #2 nrst = 1'b1;
      cyc(2);
      rd_chk(8'h00);
      power_on_det = 1'b1;
      cyc(1);
      power_on_det = 1'b0;
      cyc(10);
      rd_chk(8'h01);
      // Warm resets: aux level in Reset, tally counted unless supply low
      for (int k = 0; k < 6; k++) begin
         switcher_battery_supply_uv = k >= 3;
         d = {3'b000, k[0] ? 2'b10 : 2'b01, 1'b0, 2'(k % 3)};
         wr(d);
         sys_reset_req = 1'b1;
         cyc(1);
         sys_reset_req = 1'b0;
         cyc(2);
         check(8'(mode), 8'(FSLH_MODE_RESET));
         aux_chk(d, FSLH_MODE_RESET);
         cyc(8);
         rd_chk(d + 8'(k < 3));
      end
      switcher_battery_supply_uv = 1'b0;
      // Random settings in Normal and Standby
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         d = seed[7:0];
         {bat_undervolt, bat_overvolt, timer2_level, normal_mode_req} = seed[11:8];
         em = normal_mode_req ? FSLH_MODE_NORMAL : FSLH_MODE_STANDBY;
         wr(d);
         check(8'(mode), 8'(em));
         check(8'(limp_out_oe), 8'(d[2]));
         aux_chk(d, em);
         rd_chk(d);
      end
      // Refused frames: read-only flag, other address, short frame
      for (int r = 0; r < 3; r++) begin
         host.xfer(r == 1 ? 7'h03 : 7'h02, r == 0, ~d, r == 2 ? 12 : 16, 2, q);
         rd_chk(d);
      end
      host.xfer(7'h03, 1'b1, 8'h00, 16, 2, q);
      check(q, 8'h00);
      // Full tally turns a reset into protect mode with limp on
      wr(8'h03);
      sys_reset_req = 1'b1;
      cyc(1);
      sys_reset_req = 1'b0;
      cyc(2);
      check(8'(mode), 8'(FSLH_MODE_PROTECT));
      rd_chk(8'h07);
      // Limp I/O patterns over one hazard period per configuration
      for (int g = 0; g < 2; g++) begin
         nvm_limp_cfg = g ? 3'b011 : 3'b110;
         cyc(3);
         {n, h} = 0;
         for (int c = 0; c < 40; c++) begin
            n += limp_pwm_drive;
            h += hazard_clock_drive;
            cyc(1);
         end
         check(8'(limp_static_drive), 8'(nvm_limp_cfg[0]));
         check(8'(n), nvm_limp_cfg[1] ? 8'h04 : 8'h00);
         check(8'(h), nvm_limp_cfg[2] ? 8'h14 : 8'h00);
      end
      wr(8'h00);
      check(8'(limp_out_oe), 8'h00);
      check(8'({limp_static_drive, limp_pwm_drive, hazard_clock_drive}), 8'h00);
      // Warning interrupt, enabled then masked
      for (int e = 1; e >= 0; e--) begin
         otp_warn_irq_en = e[0];
         otp_warn = 1'b1;
         n = 0;
         repeat (4) begin
            cyc(1);
            n += overtemp_warn_irq;
         end
         otp_warn = 1'b0;
         cyc(2);
         check(8'(n), 8'(e));
      end
      // Overload entry and release through Reset
      otp_activate = 1'b1;
      cyc(3);
      check(8'(mode), 8'(FSLH_MODE_OVERLOAD));
      check(8'({limp_out_oe, sys_reset_out_n, switcher_en, can_en, lin_en, regulators_en,
                hvio_failsafe}), 8'h41);
      otp_activate = 1'b0;
      otp_release = 1'b1;
      cyc(2);
      check(8'(mode), 8'(FSLH_MODE_RESET));
      cyc(8);
      otp_release = 1'b0;
      check(8'(mode), 8'(FSLH_MODE_STANDBY));
      // Frozen clock enable holds the mode
      clk_en = 1'b0;
      normal_mode_req = 1'b1;
      cyc(5);
      check(8'(mode), 8'(FSLH_MODE_STANDBY));
      clk_en = 1'b1;
      wr(8'h04);
      check(8'(mode), 8'(FSLH_MODE_NORMAL));
      power_off_det = 1'b1;
      cyc(2);
      power_off_det = 1'b0;
      check(8'({mode, limp_out_oe}), 8'({FSLH_MODE_OFF, 1'b0}));
      finish_test;
   end

   // Hang guard, about three times the expected run
   initial begin
      #500000;
      mismatches++;
      finish_test;
   end
endmodule
